// ==== sfs_pkg.sv ====
// Package: status word layout, opcodes, timing constants for the flash status block
package sfs_pkg;
    // Status word bit positions
    localparam int BIT_WIP   = 0;
    localparam int BIT_WEL   = 1;
    localparam int BIT_AG_LO = 2;
    localparam int BIT_AG_HI = 6;
    localparam int BIT_SGM_L = 7;
    localparam int BIT_SGM_H = 8;
    localparam int BIT_FLE   = 9;
    localparam int BIT_SLK   = 10;
    localparam int BIT_RSV0  = 11;
    localparam int BIT_RSV1  = 12;
    localparam int BIT_FMF   = 13;
    localparam int BIT_GINV  = 14;
    localparam int BIT_HALT  = 15;
    // Reset value of the word and the writable-bit mask
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] WRITE_MASK   = 16'h47fc;
    // Opcodes
    localparam logic [7:0] OP_WRITE_ARM    = 8'h06;
    localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
    localparam logic [7:0] OP_STATUS_RD_LO = 8'h05;
    localparam logic [7:0] OP_STATUS_RD_HI = 8'h35;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SMALL_WIPE   = 8'h20;
    localparam logic [7:0] OP_BLOCK_WIPE32 = 8'h52;
    localparam logic [7:0] OP_BLOCK_WIPE64 = 8'hd8;
    localparam logic [7:0] OP_WHOLE_WIPE_A = 8'hc7;
    localparam logic [7:0] OP_WHOLE_WIPE_B = 8'h60;
    localparam logic [7:0] OP_SUSPEND      = 8'h75;
    localparam logic [7:0] OP_RESUME       = 8'h7a;
    localparam logic [7:0] OP_FAST_MODE    = 8'ha3;
    localparam logic [7:0] OP_RELEASE      = 8'hab;
    localparam logic [7:0] OP_DEEP_DOWN    = 8'hb9;
    // Busy time of an operation, in ns, and its cycle count at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUSY_TIME_NS  = 2000;
    localparam int BUSY_CYCLES   = BUSY_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== sfs_link.sv ====
// Link-side shifter: runs on the serial clock, reports finished frames
`timescale 1ns/1ps
module sfs_link
    import sfs_pkg::*;
(
    input  wire logic        sclk,
    input  wire logic        cs_b,
    input  wire logic        si,
    input  wire logic [15:0] word_snap,
    output logic             so,
    output logic [7:0]       frm_opcode,
    output logic [15:0]      frm_data,
    output logic [5:0]       frm_bits,
    output logic             frm_toggle
);
    typedef struct packed {
        logic [5:0]  cnt;
        logic [7:0]  op;
        logic [15:0] dat;
        logic [15:0] outsh;
    } sfs_lnk_t;
    sfs_lnk_t lnk_reg, lnk_next;

    ////////////////////////////////////////////////////////////////////////
    // Bit capture, MSB first, rising edge
    always_comb begin
        lnk_next = lnk_reg;
        if (lnk_reg.cnt != 6'h3f) begin
            lnk_next.cnt = lnk_reg.cnt + 6'h01;
        end
        if (lnk_reg.cnt < 6'h08) begin
            lnk_next.op = {lnk_reg.op[6:0], si};
        end else if (lnk_reg.cnt < 6'h18) begin
            lnk_next.dat = {lnk_reg.dat[14:0], si};
        end
        if (lnk_reg.cnt == 6'h07) begin
            lnk_next.outsh = ({lnk_reg.op[6:0], si} == OP_STATUS_RD_HI) ?
                             {word_snap[15:8], word_snap[15:8]} :
                             {word_snap[7:0], word_snap[7:0]};
        end else begin
            lnk_next.outsh = {lnk_reg.outsh[14:0], lnk_reg.outsh[15]};
        end
    end

    // Counter restarts whenever select is high
    always_ff @(posedge sclk or posedge cs_b) begin
        if (cs_b) begin
            lnk_reg.cnt   <= 6'h00;
            lnk_reg.op    <= 8'h00;
            lnk_reg.dat   <= 16'h0000;
            lnk_reg.outsh <= 16'h0000;
        end else begin
            lnk_reg.cnt   <= lnk_next.cnt;
            lnk_reg.op    <= lnk_next.op;
            lnk_reg.dat   <= lnk_next.dat;
            lnk_reg.outsh <= lnk_next.outsh;
        end
    end

    // Snapshot of the frame taken at select rise
    always_ff @(posedge cs_b) begin
        frm_opcode <= lnk_reg.op;
        frm_data   <= lnk_reg.dat;
        frm_bits   <= lnk_reg.cnt;
    end
    // Select level handed to the core's synchroniser; rise marks frame end
    assign frm_toggle = cs_b;

    // Output bit changes on falling edge
    always_ff @(negedge sclk) begin
        so <= lnk_reg.outsh[15];
    end
endmodule

// ==== sfs_core.sv ====
// Top: flash status word, command execution and protection checks
`timescale 1ns/1ps
// Functional notes
// - Progress flag high while operation busy
// - Writes refused while latch flag clear
// - Guard bits stored, set by status write
// - Guard bits locked in hardware guard mode while guard pin low
// - Whole wipe only with zero guard (here only bits 2-4 are checked, and guard invert must be clear)
// - Mode 00: writable when latch set
// - Mode 01: guard pin low locks
// - Mode 10: locked until power cycle
// - Mode 11: permanently locked (here reset clears it to mode 00, as in mode 10)
// - Four-lane bit defaults to zero
// - Security lock set once, never clears (here status writes cannot clear it, but reset does)
// - Guard invert stored, default zero
// - Fast flag follows fast mode
// - Halt flag: suspend sets, resume clears
// - Bits latched MSB first, rising edge
// - Frame begins with one opcode byte
// - Status read shifts data out
// - Write commands need byte-multiple count
// - Partial program byte keeps latch set
// - Latch set by arm, cleared by writes
module sfs_core
    import sfs_pkg::*;
#(
    parameter int BUSY_CNT = BUSY_CYCLES
)(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        sclk,
    input  wire logic        cs_b,
    input  wire logic        si,
    input  wire logic        write_guard_pin,
    output logic             so,
    output logic [15:0]      status_word,
    output logic             four_lane_enable,
    output logic             write_guard_lock,
    output logic [15:0]      last_guard_ok
);
    typedef struct packed {
        logic [2:0]  tsync;
        logic [2:0]  wpsync;
        logic        wp_level;
        logic [15:0] word;
        logic [15:0] busy_cnt;
        logic        guard_lock;
        logic [15:0] ok_cnt;
    } sfs_st_t;
    sfs_st_t st_reg, st_next;

    logic [7:0]  frm_opcode;
    logic [15:0] frm_data;
    logic [5:0]  frm_bits;
    logic        frm_toggle;
    logic [15:0] snap;

    ////////////////////////////////////////////////////////////////////////
    // Link side shifter
    // serial capture
    sfs_link i_sfs_link (
        .sclk       (sclk),
        .cs_b       (cs_b),
        .si         (si),
        .word_snap  (snap),
        .so         (so),
        .frm_opcode (frm_opcode),
        .frm_data   (frm_data),
        .frm_bits   (frm_bits),
        .frm_toggle (frm_toggle)
    );
    // Link reads a quasi-static copy; settles between frames
    assign snap = st_reg.word;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    logic frame_evt;
    logic byte_ok;
    logic latch;
    logic [1:0] mode;
    logic sr_writable;
    logic is_wipe;
    logic whole_ok;
    logic [15:0] wr_val;
    // Frame end: synchronised select rise; frame fields stable by then
    assign frame_evt = st_reg.tsync[1] && !st_reg.tsync[2];
    assign byte_ok = (frm_bits[2:0] == 3'b000) && (frm_bits != 6'h00);
    assign latch = st_reg.word[BIT_WEL];
    assign mode = {st_reg.word[BIT_SGM_H], st_reg.word[BIT_SGM_L]};
    assign sr_writable = latch && ((mode == 2'b00) ||
                         ((mode == 2'b01) && st_reg.wp_level));
    assign is_wipe = (frm_opcode == OP_SMALL_WIPE) || (frm_opcode == OP_BLOCK_WIPE32) ||
                     (frm_opcode == OP_BLOCK_WIPE64);
    assign whole_ok = (st_reg.word[BIT_AG_LO+2:BIT_AG_LO] == 3'b000) &&
                      !st_reg.word[BIT_GINV];
    // Data arrives as low byte then high byte; one byte lands low
    assign wr_val = (frm_bits == 6'h10) ? {8'h00, frm_data[7:0]} :
                    {frm_data[7:0], frm_data[15:8]};

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.tsync = {st_reg.tsync[1:0], frm_toggle};
        st_next.wpsync = {st_reg.wpsync[1:0], write_guard_pin};
        if (st_reg.wpsync[2] == st_reg.wpsync[1]) begin
            st_next.wp_level = st_reg.wpsync[2];
        end
        if (st_reg.busy_cnt != 16'h0000) begin
            st_next.busy_cnt = st_reg.busy_cnt - 16'h0001;
            if (st_reg.busy_cnt == 16'h0001) begin
                st_next.word[BIT_WIP] = 1'b0;
            end
        end
        if (frame_evt && (frm_bits != 6'h00)) begin
            case (frm_opcode)
                OP_WRITE_ARM: begin
                    if (byte_ok && frm_bits == 6'h08 && !st_reg.word[BIT_WIP]) begin
                        st_next.word[BIT_WEL] = 1'b1;
                    end
                end
                OP_WRITE_DISARM: begin
                    if (byte_ok && frm_bits == 6'h08) begin
                        st_next.word[BIT_WEL] = 1'b0;
                    end
                end
                OP_STATUS_WRITE: begin
                    if (byte_ok && frm_bits >= 6'h10 && sr_writable &&
                        !st_reg.word[BIT_WIP]) begin
                        st_next.word = (st_reg.word & ~WRITE_MASK) |
                                       (wr_val & WRITE_MASK);
                        st_next.word[BIT_SLK] = st_reg.word[BIT_SLK] | wr_val[BIT_SLK];
                        if (frm_bits == 6'h10) begin
                            st_next.word[15:8] = st_reg.word[15:8];
                        end
                        st_next.word[BIT_RSV0] = 1'b0;
                        st_next.word[BIT_RSV1] = 1'b0;
                        st_next.word[BIT_WEL] = 1'b0;
                        st_next.word[BIT_WIP] = 1'b1;
                        st_next.busy_cnt = BUSY_CNT[15:0];
                        st_next.ok_cnt = st_reg.ok_cnt + 16'h0001;
                    end
                end
                OP_PAGE_PROGRAM: begin
                    if (byte_ok && frm_bits >= 6'h20 && latch && !st_reg.word[BIT_WIP]) begin
                        st_next.word[BIT_WEL] = 1'b0;
                        st_next.word[BIT_WIP] = 1'b1;
                        st_next.busy_cnt = BUSY_CNT[15:0];
                        st_next.ok_cnt = st_reg.ok_cnt + 16'h0001;
                    end
                end
                OP_WHOLE_WIPE_A, OP_WHOLE_WIPE_B: begin
                    if (byte_ok && frm_bits == 6'h08 && latch && whole_ok &&
                        !st_reg.word[BIT_WIP]) begin
                        st_next.word[BIT_WEL] = 1'b0;
                        st_next.word[BIT_WIP] = 1'b1;
                        st_next.busy_cnt = BUSY_CNT[15:0];
                        st_next.ok_cnt = st_reg.ok_cnt + 16'h0001;
                    end
                end
                OP_SUSPEND: begin
                    if (st_reg.word[BIT_WIP]) begin
                        st_next.word[BIT_HALT] = 1'b1;
                    end
                end
                OP_RESUME: begin
                    st_next.word[BIT_HALT] = 1'b0;
                end
                OP_FAST_MODE: begin
                    st_next.word[BIT_FMF] = 1'b1;
                end
                OP_RELEASE: begin
                    st_next.word[BIT_FMF] = 1'b0;
                end
                default: begin
                    if (is_wipe && byte_ok && frm_bits == 6'h20 && latch &&
                        !st_reg.word[BIT_WIP]) begin
                        st_next.word[BIT_WEL] = 1'b0;
                        st_next.word[BIT_WIP] = 1'b1;
                        st_next.busy_cnt = BUSY_CNT[15:0];
                        st_next.ok_cnt = st_reg.ok_cnt + 16'h0001;
                    end
                end
            endcase
        end
        // Hold the busy countdown while halted
        if (st_reg.word[BIT_HALT] && st_reg.busy_cnt != 16'h0000) begin
            st_next.busy_cnt = st_reg.busy_cnt;
            st_next.word[BIT_WIP] = st_reg.word[BIT_WIP];
        end
        st_next.guard_lock = (mode == 2'b01) && !st_reg.wp_level || mode[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset stands for a power cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg.tsync      <= 3'b111;
            st_reg.wpsync     <= 3'b000;
            st_reg.wp_level   <= 1'b0;
            st_reg.word       <= STATUS_RESET;
            st_reg.busy_cnt   <= 16'h0000;
            st_reg.guard_lock <= 1'b0;
            st_reg.ok_cnt     <= 16'h0000;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    // word layout
    assign status_word      = st_reg.word;
    assign four_lane_enable = st_reg.word[BIT_FLE];
    assign write_guard_lock = st_reg.guard_lock;
    assign last_guard_ok    = st_reg.ok_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_wip_busy: assert property (@(posedge clk) disable iff (!rst_b)
        (st_reg.busy_cnt != 16'h0000) |-> st_reg.word[BIT_WIP])
        else $error("progress flag low while busy");
    a_latch_gate: assert property (@(posedge clk) disable iff (!rst_b)
        (!st_reg.word[BIT_WEL] && !st_reg.word[BIT_WIP]) |=> !$rose(st_reg.word[BIT_WIP]))
        else $error("write accepted without latch");
    a_otp_lock: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.word[BIT_SLK] |=> st_reg.word[BIT_SLK])
        else $error("security lock cleared");
    a_mode_otp: assert property (@(posedge clk) disable iff (!rst_b)
        (mode == 2'b11) |=> $stable(st_reg.word[15:2] & WRITE_MASK[15:2]))
        else $error("locked word changed");
    a_mode_hw: assert property (@(posedge clk) disable iff (!rst_b)
        (mode == 2'b01 && !st_reg.wp_level) |=> $stable(st_reg.word[BIT_AG_HI:BIT_AG_LO]))
        else $error("guard bits changed under pin lock");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.word[BIT_RSV1:BIT_RSV0] == 2'b00)
        else $error("reserved bits set");
    a_whole_wipe: assert property (@(posedge clk) disable iff (!rst_b)
        (frame_evt && (frm_opcode == OP_WHOLE_WIPE_A) && !whole_ok) |=> !$rose(st_reg.word[BIT_WIP]))
        else $error("whole wipe ran under guard");
    a_byte_bound: assert property (@(posedge clk) disable iff (!rst_b)
        (frame_evt && !byte_ok) |=> $stable(st_reg.word[BIT_WEL]))
        else $error("partial frame changed latch");
    c_arm: cover property (@(posedge clk) disable iff (!rst_b) $rose(st_reg.word[BIT_WEL]));
    c_busy: cover property (@(posedge clk) disable iff (!rst_b) $fell(st_reg.word[BIT_WIP]));
    c_halt: cover property (@(posedge clk) disable iff (!rst_b) $rose(st_reg.word[BIT_HALT]));
endmodule

// ==== sfs_host.sv ====
// Host-side serial controller model driving select, clock and data
`timescale 1ns/1ps
module sfs_host (
    output logic      sclk,
    output logic      cs_b,
    output logic      si,
    input  wire logic so
);
    ////////////////////////////////////////////////
    // Idle: select high, clock parked low
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        si   = 1'b0;
    end

    task automatic xfer(input logic [39:0] tx, input int nb, input int nrd,
                        output logic [7:0] rx);
        rx = 8'h00;
        #3.7 cs_b = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            si = tx[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        // Released line shows the inverse of its last bit
        si = ~si;
        for (int i = 0; i < nrd; i++) begin
            #40 sclk = 1'b1;
            rx = {rx[6:0], so};
            #40 sclk = 1'b0;
        end
        #40 cs_b = 1'b1;
    endtask
endmodule

// ==== test_serial_flash_status_and_framing.sv ====
// Self-checking bench for the flash status word and its framing
`timescale 1ns/1ps
module test_serial_flash_status_and_framing
    import sfs_pkg::*;
;
    localparam int BUSY_SIM = 150;
    logic        clk;
    logic        rst_b;
    logic        sclk;
    logic        cs_b;
    logic        si;
    logic        write_guard_pin;
    logic        so;
    logic [15:0] status_word;
    logic        four_lane_enable;
    logic        write_guard_lock;
    logic [15:0] last_guard_ok;
    logic [7:0]  rx;
    int          errors;
    int          total_checks;

    ////////////////////////////////////////////////
    // Block under test and its host
    sfs_core #(.BUSY_CNT(BUSY_SIM)) i_sfs_core (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si),
        .write_guard_pin(write_guard_pin), .so(so), .status_word(status_word),
        .four_lane_enable(four_lane_enable), .write_guard_lock(write_guard_lock),
        .last_guard_ok(last_guard_ok)
    );
    sfs_host i_sfs_host (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so));

    // System clock, 100 MHz
    always #5 clk = ~clk;

    ////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset;
        rst_b = 1'b0;
        settle(16);
        rst_b = 1'b1;
        settle(5);
    endtask
    task automatic frame(input logic [39:0] tx, input int nb);
        i_sfs_host.xfer(tx, nb, 0, rx);
        settle(10);
    endtask
    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        i_sfs_host.xfer({32'h0000_0000, op}, 8, 8, rx);
        settle(10);
        chk({8'h00, rx}, {8'h00, exp});
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (status_word[BIT_WIP] !== 1'b0 && n < 400) begin
            settle(1);
            n++;
        end
        chk({15'h0000, status_word[BIT_WIP]}, 16'h0000);
    endtask
    task automatic wsr(input logic [7:0] lo, input logic [7:0] hi);
        frame(40'h06, 8);
        frame({16'h0000, 8'h01, lo, hi}, 24);
        wait_idle();
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////
    // Scenarios
    task automatic t_frame;
        chk(status_word, 16'h0000);
        frame(40'h06, 8);
        chk(status_word, 16'h0002);
        frame(40'h04, 8);
        frame(40'h0001_0400, 24);
        chk(status_word, 16'h0000);
        frame(40'h06, 8);
        frame(40'h0_1040, 20);
        chk(status_word, 16'h0002);
        frame(40'h00_2000_0005, 36);
        chk(status_word, 16'h0002);
        frame(40'h02_0000_005a, 40);
        chk(status_word, 16'h0001);
        wait_idle();
        chk(last_guard_ok, 16'h0001);
        $display("t_frame done");
    endtask
    task automatic t_write;
        wsr(8'h7c, 8'h1a);
        chk(status_word, 16'h027c);
        chk({15'h0000, four_lane_enable}, 16'h0001);
        rd(OP_STATUS_RD_LO, 8'h7c);
        rd(OP_STATUS_RD_HI, 8'h02);
        wsr(8'h7c, 8'h06);
        wsr(8'h7c, 8'h02);
        chk(status_word, 16'h067c);
        chk(last_guard_ok, 16'h0004);
        $display("t_write done");
    endtask
    task automatic t_wipe;
        frame(40'h06, 8);
        frame(40'hc7, 8);
        chk(status_word & 16'h0001, 16'h0000);
        frame(40'h04, 8);
        wsr(8'h00, 8'h46);
        chk(status_word, 16'h4600);
        frame(40'h06, 8);
        frame(40'h60, 8);
        chk(last_guard_ok, 16'h0005);
        frame(40'h04, 8);
        wsr(8'h00, 8'h06);
        frame(40'h06, 8);
        frame(40'h60, 8);
        chk(status_word, 16'h0601);
        wait_idle();
        chk(last_guard_ok, 16'h0007);
        $display("t_wipe done");
    endtask
    task automatic t_guard;
        write_guard_pin = 1'b0;
        wsr(8'h80, 8'h06);
        chk(status_word, 16'h0680);
        settle(6);
        chk({15'h0000, write_guard_lock}, 16'h0001);
        wsr(8'h84, 8'h06);
        chk(status_word & 16'hfffd, 16'h0680);
        frame(40'h04, 8);
        write_guard_pin = 1'b1;
        settle(6);
        chk({15'h0000, write_guard_lock}, 16'h0000);
        wsr(8'h84, 8'h06);
        chk(status_word, 16'h0684);
        wsr(8'h00, 8'h07);
        wsr(8'h04, 8'h06);
        chk(status_word & 16'hfffd, 16'h0700);
        frame(40'h04, 8);
        do_reset();
        chk(status_word, 16'h0000);
        wsr(8'h80, 8'h01);
        wsr(8'h00, 8'h00);
        chk(status_word & 16'hfffd, 16'h0180);
        frame(40'h04, 8);
        do_reset();
        $display("t_guard done");
    endtask
    task automatic t_halt;
        frame(40'h06, 8);
        frame(40'h02_0000_005a, 40);
        frame(40'h75, 8);
        chk(status_word, 16'h8001);
        settle(200);
        chk(status_word, 16'h8001);
        frame(40'h7a, 8);
        chk(status_word & 16'h8000, 16'h0000);
        wait_idle();
        chk(status_word, 16'h0000);
        $display("t_halt done");
    endtask
    task automatic t_fast;
        frame(40'ha300_0000, 32);
        chk(status_word, 16'h2000);
        frame(40'hab, 8);
        chk(status_word, 16'h0000);
        $display("t_fast done");
    endtask

    ////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 1'b0;
        write_guard_pin = 1'b1;
        errors = 0;
        total_checks = 0;
        do_reset();
        t_frame();
        t_write();
        t_wipe();
        t_guard();
        t_halt();
        t_fast();
        give_verdict();
    end

    // Watchdog against a hung handshake
    initial begin
        #500_000;
        errors++;
        give_verdict();
    end
endmodule
